// ### shared/pcof_pkg.sv
// package for the pack configuration word and over-temperature flag block
// assumes a single 20 MHz clock and an AXI4-Lite master with 32-bit data
package pcof_pkg;

	// clock and timing
	localparam int unsigned PCOF_CLK_KHZ = 20000;
	localparam int unsigned PCOF_TICK_TIME_MS = 1000; // delay unit of the over-temperature timers
	localparam int unsigned PCOF_TICK_CYCLES = PCOF_TICK_TIME_MS * PCOF_CLK_KHZ;

	// register byte offsets
	localparam logic [7:0] PCOF_OFS_PACK_CFG = 8'h00;
	localparam logic [7:0] PCOF_OFS_CHG_LIMIT = 8'h04;
	localparam logic [7:0] PCOF_OFS_CHG_RELEASE = 8'h08;
	localparam logic [7:0] PCOF_OFS_CHG_DELAY = 8'h0c;
	localparam logic [7:0] PCOF_OFS_DSG_LIMIT = 8'h10;
	localparam logic [7:0] PCOF_OFS_DSG_RELEASE = 8'h14;
	localparam logic [7:0] PCOF_OFS_DSG_DELAY = 8'h18;
	localparam logic [7:0] PCOF_OFS_CHG_CUR_THR = 8'h1c;
	localparam logic [7:0] PCOF_OFS_DSG_CUR_THR = 8'h20;
	localparam logic [7:0] PCOF_OFS_FLAGS = 8'h24;
	localparam logic [7:0] PCOF_OFS_INT_STATUS = 8'h28;
	localparam logic [7:0] PCOF_OFS_INT_CLEAR = 8'h2c;
	localparam logic [7:0] PCOF_OFS_INT_ENABLE = 8'h30;

	// reset values
	localparam logic [15:0] PCOF_PACK_CFG_RST = 16'h0171;
	localparam logic [15:0] PCOF_PACK_CFG_WMASK = 16'hcff1; // reserved positions never stored
	localparam logic [15:0] PCOF_CHG_LIMIT_RST = 16'h0000;
	localparam logic [15:0] PCOF_CHG_RELEASE_RST = 16'h0000;
	localparam logic [15:0] PCOF_DSG_LIMIT_RST = 16'h0000;
	localparam logic [15:0] PCOF_DSG_RELEASE_RST = 16'h0000;
	localparam logic [15:0] PCOF_DELAY_RST = 16'h0000;
	localparam logic [15:0] PCOF_CUR_THR_RST = 16'h0000;

	// flag and interrupt bit positions
	localparam int PCOF_CH_CHG = 0;
	localparam int PCOF_CH_DSG = 1;
	localparam int PCOF_EV_CHG_SET = 0;
	localparam int PCOF_EV_DSG_SET = 1;
	localparam int PCOF_EV_CHG_CLR = 2;
	localparam int PCOF_EV_DSG_CLR = 3;
	localparam int PCOF_EV_TERM = 4;
	localparam int PCOF_NEV = 5;

	// bus answers
	localparam logic [1:0] PCOF_RESP_OKAY = 2'b00;
	localparam logic [1:0] PCOF_RESP_SLVERR = 2'b10;

	// configuration word layout, high byte first
	typedef struct packed {
		logic noload_reserve_select;
		logic calibration_permit;
		logic [1:0] rsvd_hi;
		logic voltage_input_select;
		logic current_wake_level;
		logic sense_range_hi;
		logic sense_range_lo;
		logic tenfold_scale_flag;
		logic resistance_factor_stepping;
		logic sleep_permit;
		logic capacity_sync_on_full;
		logic [2:0] rsvd_lo;
		logic external_sensor_select;
	} pcof_cfg_t;

	// per-channel thresholds
	typedef struct packed {
		logic signed [15:0] limit;
		logic signed [15:0] release_level;
		logic [15:0] delay;
	} pcof_ot_t;

endpackage

// ### src/pcof_core.sv
// pack configuration word, over-temperature flags and their AXI4-Lite register file
// assumes temperature, current and capacity inputs come from gauge logic on aclk
`timescale 1ns/1ps

// What this block does
// R1 - holds a sixteen-bit configuration word, high and low byte, bits seven to zero
// R2 - software leaves reserved low-byte positions unused; they store nothing here
// R3 - sleep permission bit gates sleep entry; defaults to one
// R4 - capacity sync bit loads remaining capacity from full capacity at termination
// R5 - sensor select bit picks external thermistor, else on-chip sensor; defaults to one
// R6 - charge flag sets after limit held for delay while current above charge threshold
// R7 - charge delay of zero disables charge over-temperature detection
// R8 - charge flag clears when temperature falls to the charge release level
// R9 - discharge flag sets after limit held for delay while current at or below negated threshold
// R10 - discharge delay of zero disables discharge over-temperature detection
// R11 - discharge flag clears when temperature falls to the discharge release level
// R12 - flags hold between levels; delay count restarts when the condition lapses
module pcof_core import pcof_pkg::*; #(
	parameter int unsigned TICK_CYCLES = PCOF_TICK_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// gauge measurements
	input wire logic signed [15:0] internal_temperature,
	input wire logic signed [15:0] external_temperature,
	input wire logic signed [15:0] average_current,
	input wire logic charge_termination,
	input wire logic [15:0] full_charge_capacity,
	input wire logic sleep_conditions_ok,
	// results
	output logic signed [15:0] temperature,
	output logic sleep_enter,
	output logic remaining_capacity_load,
	output logic [15:0] remaining_capacity_value,
	output logic charge_overtemp_flag,
	output logic discharge_overtemp_flag,
	output logic irq
);

	// registers
	logic [15:0] pack_configuration_word;
	pcof_ot_t ot_cfg [2];
	logic [15:0] chg_cur_thr;
	logic [15:0] dsg_cur_thr;
	logic [PCOF_NEV-1:0] int_status;
	logic [PCOF_NEV-1:0] int_enable;
	logic [1:0] ot_flag;
	logic [1:0] ot_set_ev;
	logic [1:0] ot_clr_ev;
	pcof_cfg_t cfg;

	// bus holding state
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_hold;
	logic w_hold;
	logic do_write;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic wr_map;

	// one-second tick
	logic [31:0] tick_cnt;
	logic tick;

	assign cfg = pcof_cfg_t'(pack_configuration_word);

	// byte-lane merge for the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// write address channel; one write in flight, so ready drops until the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_hold <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_hold <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_hold <= 1'b0;
		end else if (!aw_hold && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_hold <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_hold <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_hold <= 1'b0;
		end else if (!w_hold && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign do_write = aw_hold && w_hold && !s_axi_bvalid;

	// address decode for writes; flags and status are read-only and answer with an error
	always_comb begin
		case (aw_addr)
			PCOF_OFS_PACK_CFG, PCOF_OFS_CHG_LIMIT, PCOF_OFS_CHG_RELEASE, PCOF_OFS_CHG_DELAY,
			PCOF_OFS_DSG_LIMIT, PCOF_OFS_DSG_RELEASE, PCOF_OFS_DSG_DELAY,
			PCOF_OFS_CHG_CUR_THR, PCOF_OFS_DSG_CUR_THR, PCOF_OFS_INT_CLEAR,
			PCOF_OFS_INT_ENABLE: wr_map = 1'b1;
			default: wr_map = 1'b0;
		endcase
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PCOF_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? PCOF_RESP_OKAY : PCOF_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// configuration word; reserved positions are masked so they always read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pack_configuration_word <= PCOF_PACK_CFG_RST; // R1 R3 R4 R5
		end else if (do_write && aw_addr == PCOF_OFS_PACK_CFG) begin
			pack_configuration_word <= merge16(pack_configuration_word, w_data, w_strb)
				& PCOF_PACK_CFG_WMASK; // R1 R2
		end
	end

	// thresholds and delays
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ot_cfg[PCOF_CH_CHG] <= {PCOF_CHG_LIMIT_RST, PCOF_CHG_RELEASE_RST, PCOF_DELAY_RST};
			ot_cfg[PCOF_CH_DSG] <= {PCOF_DSG_LIMIT_RST, PCOF_DSG_RELEASE_RST, PCOF_DELAY_RST};
			chg_cur_thr <= PCOF_CUR_THR_RST;
			dsg_cur_thr <= PCOF_CUR_THR_RST;
		end else if (do_write) begin
			case (aw_addr)
				PCOF_OFS_CHG_LIMIT: ot_cfg[PCOF_CH_CHG].limit <=
					merge16(ot_cfg[PCOF_CH_CHG].limit, w_data, w_strb);
				PCOF_OFS_CHG_RELEASE: ot_cfg[PCOF_CH_CHG].release_level <=
					merge16(ot_cfg[PCOF_CH_CHG].release_level, w_data, w_strb);
				PCOF_OFS_CHG_DELAY: ot_cfg[PCOF_CH_CHG].delay <=
					merge16(ot_cfg[PCOF_CH_CHG].delay, w_data, w_strb);
				PCOF_OFS_DSG_LIMIT: ot_cfg[PCOF_CH_DSG].limit <=
					merge16(ot_cfg[PCOF_CH_DSG].limit, w_data, w_strb);
				PCOF_OFS_DSG_RELEASE: ot_cfg[PCOF_CH_DSG].release_level <=
					merge16(ot_cfg[PCOF_CH_DSG].release_level, w_data, w_strb);
				PCOF_OFS_DSG_DELAY: ot_cfg[PCOF_CH_DSG].delay <=
					merge16(ot_cfg[PCOF_CH_DSG].delay, w_data, w_strb);
				PCOF_OFS_CHG_CUR_THR: chg_cur_thr <= merge16(chg_cur_thr, w_data, w_strb);
				PCOF_OFS_DSG_CUR_THR: dsg_cur_thr <= merge16(dsg_cur_thr, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// interrupt enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_enable <= '0;
		end else if (do_write && aw_addr == PCOF_OFS_INT_ENABLE && w_strb[0]) begin
			int_enable <= w_data[PCOF_NEV-1:0];
		end
	end

	// sticky status; a new event in the clearing cycle wins so none is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_status <= '0;
		end else begin
			logic [PCOF_NEV-1:0] clr;
			logic [PCOF_NEV-1:0] ev;
			clr = '0;
			ev = {charge_termination, ot_clr_ev, ot_set_ev};
			if (do_write && aw_addr == PCOF_OFS_INT_CLEAR && w_strb[0]) begin
				clr = w_data[PCOF_NEV-1:0];
			end
			int_status <= (int_status & ~clr) | ev;
		end
	end

	// level interrupt, registered so the pin has no combinational path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_enable);
		end
	end

	// read decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		case (s_axi_araddr)
			PCOF_OFS_PACK_CFG: next_rdata = {16'h0000, pack_configuration_word};
			PCOF_OFS_CHG_LIMIT: next_rdata = {16'h0000, ot_cfg[PCOF_CH_CHG].limit};
			PCOF_OFS_CHG_RELEASE: next_rdata = {16'h0000, ot_cfg[PCOF_CH_CHG].release_level};
			PCOF_OFS_CHG_DELAY: next_rdata = {16'h0000, ot_cfg[PCOF_CH_CHG].delay};
			PCOF_OFS_DSG_LIMIT: next_rdata = {16'h0000, ot_cfg[PCOF_CH_DSG].limit};
			PCOF_OFS_DSG_RELEASE: next_rdata = {16'h0000, ot_cfg[PCOF_CH_DSG].release_level};
			PCOF_OFS_DSG_DELAY: next_rdata = {16'h0000, ot_cfg[PCOF_CH_DSG].delay};
			PCOF_OFS_CHG_CUR_THR: next_rdata = {16'h0000, chg_cur_thr};
			PCOF_OFS_DSG_CUR_THR: next_rdata = {16'h0000, dsg_cur_thr};
			PCOF_OFS_FLAGS: next_rdata = {30'h0000_0000, ot_flag};
			PCOF_OFS_INT_STATUS: next_rdata = {27'h000_0000, int_status};
			PCOF_OFS_INT_CLEAR: next_rdata = 32'h0000_0000; // write-only, reads zero
			PCOF_OFS_INT_ENABLE: next_rdata = {27'h000_0000, int_enable};
			default: next_rerr = 1'b1;
		endcase
	end

	// read channel; address ready drops until the data is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= PCOF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rerr ? PCOF_RESP_SLVERR : PCOF_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// one-second enable; long count, shortened through the parameter in simulation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	// temperature source selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temperature <= 16'sh0000;
		end else begin
			temperature <= cfg.external_sensor_select ? external_temperature
				: internal_temperature; // R5
		end
	end

	// sleep permission; when clear the gauge is held out of sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_enter <= 1'b0;
		end else begin
			sleep_enter <= cfg.sleep_permit && sleep_conditions_ok; // R3
		end
	end

	// capacity copy on valid termination, one-cycle load strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remaining_capacity_load <= 1'b0;
			remaining_capacity_value <= 16'h0000;
		end else begin
			remaining_capacity_load <= charge_termination && cfg.capacity_sync_on_full; // R4
			if (charge_termination) begin
				remaining_capacity_value <= full_charge_capacity;
			end
		end
	end

	// current direction, compared one bit wider so negating the threshold cannot overflow
	logic [1:0] cur_ok;
	assign cur_ok[PCOF_CH_CHG] = 17'(average_current) > $signed({1'b0, chg_cur_thr}); // R6
	assign cur_ok[PCOF_CH_DSG] = 17'(average_current) <= -$signed({1'b0, dsg_cur_thr}); // R9

	// per-channel delay timer and hysteresis flag
	for (genvar ch = 0; ch < 2; ch++) begin : g_ot
		logic [15:0] hold_cnt;
		logic armed;
		logic hot;
		logic cool;
		assign hot = temperature >= ot_cfg[ch].limit;
		assign cool = temperature <= ot_cfg[ch].release_level;
		assign armed = hot && cur_ok[ch] && ot_cfg[ch].delay != 16'h0000; // R7 R10

		// seconds the set condition has held; any lapse restarts it
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				hold_cnt <= 16'h0000;
			end else if (!armed) begin
				hold_cnt <= 16'h0000; // R12
			end else if (tick && hold_cnt != 16'hffff) begin
				hold_cnt <= hold_cnt + 16'h0001; // R6 R9
			end
		end

		// set after the delay, clear at release, otherwise keep the state
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ot_flag[ch] <= 1'b0;
				ot_set_ev[ch] <= 1'b0;
				ot_clr_ev[ch] <= 1'b0;
			end else begin
				ot_set_ev[ch] <= 1'b0;
				ot_clr_ev[ch] <= 1'b0;
				if (armed && hold_cnt >= ot_cfg[ch].delay && !ot_flag[ch]) begin
					ot_flag[ch] <= 1'b1; // R6 R9
					ot_set_ev[ch] <= 1'b1;
				end else if (cool && ot_flag[ch]) begin
					ot_flag[ch] <= 1'b0; // R8 R11
					ot_clr_ev[ch] <= 1'b1;
				end
			end
		end
	end

	// flag outputs follow the flag flip-flops directly
	assign charge_overtemp_flag = ot_flag[PCOF_CH_CHG];
	assign discharge_overtemp_flag = ot_flag[PCOF_CH_DSG];

endmodule // pcof_core

// ### tb/pcof_core_properties.sv
// bus timing and gauge output checks for pcof_core, ports only
// assumes one aclk domain with synchronous active-low reset
`timescale 1ns/1ps
module pcof_core_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// gauge side
	input wire logic signed [15:0] internal_temperature,
	input wire logic signed [15:0] external_temperature,
	input wire logic charge_termination,
	input wire logic [15:0] full_charge_capacity,
	input wire logic sleep_conditions_ok,
	input wire logic signed [15:0] temperature,
	input wire logic sleep_enter,
	input wire logic remaining_capacity_load,
	input wire logic [15:0] remaining_capacity_value
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// both write halves taken at one edge
	sequence s_write_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// read answer one edge after the request; write answer two, the halves are merged first
	a_write_answer_due: assert property (s_write_both |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer_due: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_aw_busy_after: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address accepted twice");
	// gauge outputs follow their causes one cycle later
	a_temp_from_source: assert property (1'b1 |=> temperature == $past(internal_temperature)
		|| temperature == $past(external_temperature)) else $error("temperature from nowhere");
	a_capacity_copy: assert property (charge_termination
		|=> remaining_capacity_value == $past(full_charge_capacity))
		else $error("capacity not copied");
	a_load_has_cause: assert property (remaining_capacity_load |-> $past(charge_termination))
		else $error("load without termination");
	a_sleep_has_cause: assert property (!sleep_conditions_ok |=> !sleep_enter)
		else $error("sleep without conditions");
endmodule // pcof_core_properties

// ### tb/pcof_core_tb.sv
// self-checking bench for pcof_core with a host model on the register bus
// assumes TICK_CYCLES cut to ten so the delays finish quickly
`timescale 1ns/1ps
module pcof_core_tb;
	import pcof_pkg::*;
	localparam int unsigned TICK = 10;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, x, rdv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic signed [15:0] internal_temperature = 16'sh0, external_temperature = 16'sh0;
	logic signed [15:0] average_current = 16'sh0, temperature;
	logic [15:0] full_charge_capacity = 16'h0, remaining_capacity_value;
	logic charge_termination = 1'b0, sleep_conditions_ok = 1'b0, sleep_enter;
	logic remaining_capacity_load, charge_overtemp_flag, discharge_overtemp_flag, irq;
	logic [31:0] seed = 32'h5794;
	int n_mismatch = 0;
	int n_checks = 0;
	pcof_core #(.TICK_CYCLES(TICK)) pcof_core_i (.*);
	pcof_host pcof_host_i (.*);
	// 20 MHz clock
	always #25 aclk = ~aclk;
	// xorshift source of the random samples
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// reserved positions never hold a one
	function automatic logic [15:0] cfg_expect(input logic [15:0] w);
		return w & ~16'h300e;
	endfunction
	function automatic logic [31:0] flag(input logic ch);
		return {31'h0, ch ? discharge_overtemp_flag : charge_overtemp_flag};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic meas(input logic signed [15:0] t, input logic signed [15:0] c);
		internal_temperature <= t;
		external_temperature <= t;
		average_current <= c;
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one channel: limit 0x64, release 0x32, current threshold 0xa, delay last
	task automatic ot_case(input logic ch, input logic [15:0] dly);
		logic [7:0] b;
		logic signed [15:0] c;
		logic [31:0] on;
		b = ch ? 8'h10 : 8'h04;
		c = ch ? -16'sh14 : 16'sh14;
		on = {31'h0, dly != 16'h0};
		pcof_host_i.write(b, 32'h64, rsp);
		pcof_host_i.write(b + 8'h04, 32'h32, rsp);
		pcof_host_i.write(ch ? 8'h20 : 8'h1c, 32'ha, rsp);
		pcof_host_i.write(b + 8'h08, {16'h0, dly}, rsp);
		meas(16'sh78, c);
		repeat (7) @(posedge aclk);
		check(flag(ch), 32'h0);
		repeat (TICK * 4) @(posedge aclk);
		check(flag(ch), on);
		meas(16'sh46, c);
		repeat (5) @(posedge aclk);
		check(flag(ch), on);
		meas(16'sh32, c);
		repeat (4) @(posedge aclk);
		check(flag(ch), 32'h0);
		// the set and clear events of this channel reach the sticky status
		pcof_host_i.read(8'h28, rdv, rsp);
		check(rdv & (32'h5 << ch), on ? (32'h5 << ch) : 32'h0);
		pcof_host_i.write(8'h2c, 32'hf, rsp);
		pcof_host_i.write(b + 8'h08, 32'h0, rsp);
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		pcof_host_i.read(8'h00, rdv, rsp);
		check(rdv, 32'h171);
		pcof_host_i.slow = 1'b1;
		pcof_host_i.write(8'h00, 32'hffff, rsp);
		check({30'h0, rsp}, {30'h0, PCOF_RESP_OKAY});
		pcof_host_i.read(8'h00, rdv, rsp);
		check(rdv, {16'h0, cfg_expect(16'hffff)});
		pcof_host_i.read(8'h40, rdv, rsp);
		check({30'h0, rsp}, {30'h0, PCOF_RESP_SLVERR});
		pcof_host_i.write(8'h24, 32'h3, rsp);
		check({30'h0, rsp}, {30'h0, PCOF_RESP_SLVERR});
		pcof_host_i.slow = 1'b0;
		for (int s = 0; s < 2; s++) begin
			pcof_host_i.write(8'h00, s ? 32'h30 : 32'h31, rsp);
			repeat (3) begin
				x = xs();
				internal_temperature <= x[15:0];
				external_temperature <= x[31:16];
				repeat (2) @(posedge aclk);
				check({16'h0, temperature}, {16'h0, s ? x[15:0] : x[31:16]});
			end
		end
		sleep_conditions_ok <= 1'b1;
		repeat (3) @(posedge aclk);
		check({31'h0, sleep_enter}, 32'h1);
		pcof_host_i.write(8'h00, 32'h10, rsp);
		repeat (3) @(posedge aclk);
		check({31'h0, sleep_enter}, 32'h0);
		for (int s = 0; s < 2; s++) begin
			x = xs();
			full_charge_capacity <= x[15:0];
			charge_termination <= 1'b1;
			@(posedge aclk);
			charge_termination <= 1'b0;
			@(posedge aclk);
			check({31'h0, remaining_capacity_load}, {31'h0, s == 0});
			check({16'h0, remaining_capacity_value}, {16'h0, x[15:0]});
			pcof_host_i.write(8'h00, 32'h0, rsp);
		end
		check({31'h0, irq}, 32'h0); // event masked
		pcof_host_i.write(8'h30, 32'h10, rsp);
		repeat (3) @(posedge aclk);
		check({31'h0, irq}, 32'h1);
		pcof_host_i.read(8'h28, rdv, rsp);
		check(rdv & 32'h10, 32'h10);
		pcof_host_i.write(8'h2c, 32'h10, rsp);
		repeat (3) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		ot_case(1'b0, 16'h0);
		ot_case(1'b0, 16'h2);
		ot_case(1'b1, 16'h0);
		ot_case(1'b1, 16'h3);
		report_and_stop();
	end
	// a hang ends the run as a mismatch
	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		report_and_stop();
	end
endmodule // pcof_core_tb
bind pcof_core pcof_core_properties pcof_core_properties_i (.*);

// ### tb/pcof_host.sv
// host side AXI4-Lite master for pcof_core, driven through its tasks
// assumes the bench shares aclk; slow holds off bready and rready
`timescale 1ns/1ps
module pcof_host (
	// clock
	input wire logic aclk,
	// write
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	logic slow = 1'b0; // a slow host lets the answer wait one cycle
	// idle bus at time zero
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end
	// one write; each half is released at its own handshake
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// stale payload must not pass for the last one
		s_axi_awaddr <= ~a;
		s_axi_wdata <= ~d;
	endtask
	// one read
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~a;
	endtask
endmodule // pcof_host
